// File: common/tgi_pkg.sv
// shared constants and types for the three-phase gate command controller
package tgi_pkg;

  // clock and timing figures in their own units
  localparam int CLK_PERIOD_NS   = 40;
  localparam int DEAD_TIME_NS    = 500;
  localparam int MIN_PULSE_NS    = 1000;
  localparam int SETTLE_CYC_INT  = 2;

  // cycle counts: least times round up
  localparam int DEAD_CYC_INT  = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC_INT = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // timer width and sized forms of the counts
  localparam int TMR_W = 5;
  localparam logic [TMR_W-1:0] DEAD_CYC   = TMR_W'(DEAD_CYC_INT);
  localparam logic [TMR_W-1:0] PULSE_CYC  = TMR_W'(PULSE_CYC_INT);
  localparam logic [TMR_W-1:0] SETTLE_CYC = TMR_W'(SETTLE_CYC_INT);
  localparam logic [TMR_W-1:0] TMR_ZERO   = 5'h00;

  // number of phases
  localparam int PHASES = 3;

  // user request codes per phase
  localparam logic [1:0] REQ_OFF  = 2'h0;
  localparam logic [1:0] REQ_BUS  = 2'h1;
  localparam logic [1:0] REQ_GND  = 2'h2;

  // reset values
  localparam logic LEG_CMD_RST   = 1'h0;
  localparam logic LINE_OE_N_RST = 1'h0;

  // enable/fault line handling states
  typedef enum logic [1:0] {
    TGI_DISABLED = 2'b00,
    TGI_ENABLED  = 2'b01,
    TGI_FAULT    = 2'b10
  } tgi_state_t;

  // one leg's pair of gate commands
  typedef struct packed {
    logic high;
    logic low;
  } tgi_leg_t;

endpackage

// File: hw/tgi_ctrl.sv
// controller driving the gate command inputs and enable/fault line of a three-phase module
`timescale 1ns/10ps
`default_nettype none
module tgi_ctrl
  import tgi_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // user requests per phase and enable
  input  wire logic [1:0] req_phase_a_in,
  input  wire logic [1:0] req_phase_b_in,
  input  wire logic [1:0] req_phase_c_in,
  input  wire logic       enable_req_in,
  input  wire logic       fault_clear_in,
  // user status
  output logic            fault_out,
  output logic            running_out,
  // gate command pins
  output logic            high_cmd_phase_a_out,
  output logic            high_cmd_phase_b_out,
  output logic            high_cmd_phase_c_out,
  output logic            low_cmd_phase_a_out,
  output logic            low_cmd_phase_b_out,
  output logic            low_cmd_phase_c_out,
  // enable/fault line, open drain
  input  wire logic       enable_fault_line_in,
  output logic            enable_fault_line_out,
  output logic            enable_fault_line_oe_n_out
);

  tgi_state_t        state_reg;
  tgi_state_t        state_next;
  logic [TMR_W-1:0]  settle_reg;
  logic [TMR_W-1:0]  settle_next;
  logic              oe_n_reg;
  logic              oe_n_next;
  logic              fault_reg;
  logic              fault_next;
  logic              drive_zero_reg;
  logic              running_reg;
  logic              running_next;
  wire               settled;
  wire               line_fault;
  wire               force_off;
  wire  [1:0]        req_vec [PHASES];
  tgi_leg_t          leg_vec [PHASES];

  // the pull-up needs a few cycles to lift the line after release, so early lows are no fault
  // a low line after the release has settled is the device's fault report
  assign settled    = (settle_reg >= SETTLE_CYC);
  assign line_fault = (state_reg == TGI_ENABLED) && settled && !enable_fault_line_in;
  // the device sinks the line on its own faults, so a low level always stops the commands
  // commands are held off whenever the line is not released and high
  assign force_off  = (state_reg != TGI_ENABLED) || !enable_fault_line_in
                    || line_fault;

  // enable/fault line sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TGI_DISABLED: begin
        if (enable_req_in) begin
          state_next = TGI_ENABLED;
        end
      end
      TGI_ENABLED: begin
        if (!enable_req_in) begin
          state_next = TGI_DISABLED;
        end else if (line_fault) begin
          state_next = TGI_FAULT;
        end
      end
      TGI_FAULT: begin
        if (!enable_req_in) begin
          state_next = TGI_DISABLED;
        end else if (fault_clear_in && enable_fault_line_in) begin
          state_next = TGI_ENABLED;
        end
      end
      default: begin
        state_next = TGI_DISABLED;
      end
    endcase
  end

  // settle timer restarts when the line is released
  assign settle_next = (state_next != TGI_ENABLED || state_reg == TGI_DISABLED) ? TMR_ZERO
                     : (settled ? settle_reg : settle_reg + 5'h01);
  // line is pulled low only while disabled
  assign oe_n_next   = (state_next != TGI_DISABLED);
  // the clear only counts once the device has let the line rise again
  // sticky fault flag: a new fault wins over a clear
  assign fault_next  = line_fault || (fault_reg && !(fault_clear_in && state_reg == TGI_FAULT
                       && enable_fault_line_in));
  // running flag registered beside the state so the status pin comes from a flip-flop
  assign running_next = (state_next == TGI_ENABLED);

  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg      <= TGI_DISABLED;
      settle_reg     <= TMR_ZERO;
      oe_n_reg       <= LINE_OE_N_RST;
      fault_reg      <= 1'h0;
      drive_zero_reg <= 1'h0;
      running_reg    <= 1'h0;
    end else begin
      state_reg      <= state_next;
      settle_reg     <= settle_next;
      oe_n_reg       <= oe_n_next;
      fault_reg      <= fault_next;
      drive_zero_reg <= 1'h0;                 // line data bit stays low; only the enable moves
      running_reg    <= running_next;
    end
  end

  // one leg per phase, a to c in order
  // all legs share one shut-off so a fault stops every phase on the same edge
  assign req_vec[0] = req_phase_a_in;
  assign req_vec[1] = req_phase_b_in;
  assign req_vec[2] = req_phase_c_in;

  for (genvar p = 0; p < PHASES; p++) begin : g_leg
    tgi_leg u_leg (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .req_in       (req_vec[p]),
      .force_off_in (force_off),
      .leg_out      (leg_vec[p])
    );
  end

  // pin outputs, each straight from a flip-flop
  // the line is only ever pulled down, never driven high
  assign high_cmd_phase_a_out       = leg_vec[0].high;
  assign low_cmd_phase_a_out        = leg_vec[0].low;
  assign high_cmd_phase_b_out       = leg_vec[1].high;
  assign low_cmd_phase_b_out        = leg_vec[1].low;
  assign high_cmd_phase_c_out       = leg_vec[2].high;
  assign low_cmd_phase_c_out        = leg_vec[2].low;
  assign enable_fault_line_out      = drive_zero_reg;
  assign enable_fault_line_oe_n_out = oe_n_reg;
  assign fault_out                  = fault_reg;
  assign running_out                = running_reg;

  // checks on the line handling
  fault_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    line_fault && enable_req_in |=> (state_reg == TGI_FAULT) && fault_out && !high_cmd_phase_a_out
    && !low_cmd_phase_a_out && !high_cmd_phase_b_out && !low_cmd_phase_b_out
    && !high_cmd_phase_c_out && !low_cmd_phase_c_out)
    else $error("commands not dropped on line fault");

  disable_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !enable_req_in |=> !enable_fault_line_oe_n_out && !enable_fault_line_out)
    else $error("line not pulled low when disabled");

  disabled_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !enable_req_in ##1 !enable_req_in |=> !high_cmd_phase_a_out && !high_cmd_phase_b_out
    && !high_cmd_phase_c_out && !low_cmd_phase_a_out && !low_cmd_phase_b_out
    && !low_cmd_phase_c_out)
    else $error("commands active while disabled");

  fault_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == TGI_FAULT) && enable_req_in && !fault_clear_in |=> state_reg == TGI_FAULT)
    else $error("fault left without clear");

  // checks on line release, fault clear, forced shut-off and phase mapping
  enable_go_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == TGI_DISABLED) && enable_req_in |=> running_out && enable_fault_line_oe_n_out)
    else $error("line not released on enable");

  held_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    state_reg == TGI_DISABLED |-> !enable_fault_line_oe_n_out)
    else $error("line released while disabled");

  line_low_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !enable_fault_line_in |=> !high_cmd_phase_a_out && !high_cmd_phase_b_out
    && !high_cmd_phase_c_out && !low_cmd_phase_a_out && !low_cmd_phase_b_out
    && !low_cmd_phase_c_out)
    else $error("commands active while line low");

  early_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == TGI_ENABLED) && !settled && enable_req_in |=> state_reg == TGI_ENABLED)
    else $error("fault taken before the line settled");

  clear_back_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == TGI_FAULT) && enable_req_in && fault_clear_in && enable_fault_line_in
    |=> running_out && !fault_out)
    else $error("fault clear not taken");

  clear_refused_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == TGI_FAULT) && !enable_fault_line_in |=> !running_out && fault_out)
    else $error("fault cleared while line low");

  fault_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in)
    fault_out && !((state_reg == TGI_FAULT) && fault_clear_in && enable_fault_line_in)
    |=> fault_out)
    else $error("fault flag dropped without clear");

  bus_map_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(high_cmd_phase_a_out) |-> $past(req_phase_a_in) == REQ_BUS)
    and ($rose(high_cmd_phase_b_out) |-> $past(req_phase_b_in) == REQ_BUS)
    and ($rose(high_cmd_phase_c_out) |-> $past(req_phase_c_in) == REQ_BUS))
    else $error("high command raised without its phase asking for the bus");

  gnd_map_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(low_cmd_phase_a_out) |-> $past(req_phase_a_in) == REQ_GND)
    and ($rose(low_cmd_phase_b_out) |-> $past(req_phase_b_in) == REQ_GND)
    and ($rose(low_cmd_phase_c_out) |-> $past(req_phase_c_in) == REQ_GND))
    else $error("low command raised without its phase asking for ground");

endmodule
`default_nettype wire

// File: hw/tgi_leg.sv
// one phase leg: dead time, minimum pulse width and forced shut-off
`timescale 1ns/10ps
`default_nettype none
module tgi_leg
  import tgi_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // request side
  input  wire logic [1:0] req_in,
  input  wire logic       force_off_in,
  // command side
  output tgi_leg_t        leg_out
);

  logic             hi_reg;
  logic             hi_next;
  logic             lo_reg;
  logic             lo_next;
  logic [TMR_W-1:0] t_hi_reg;
  logic [TMR_W-1:0] t_hi_next;
  logic [TMR_W-1:0] t_lo_reg;
  logic [TMR_W-1:0] t_lo_next;
  wire              want_hi;
  wire              want_lo;
  wire              hi_may_turn;
  wire              lo_may_turn;

  // decode the request
  assign want_hi     = (req_in == REQ_BUS);
  assign want_lo     = (req_in == REQ_GND);
  assign hi_may_turn = (t_hi_reg >= PULSE_CYC);
  assign lo_may_turn = (t_lo_reg >= PULSE_CYC);

  // next gate commands; a switch turns on only after the other has been off long enough
  assign hi_next = hi_reg ? !(force_off_in || (!want_hi && hi_may_turn))
                 : (want_hi && !force_off_in && !lo_reg && hi_may_turn
                    && t_lo_reg >= DEAD_CYC);
  assign lo_next = lo_reg ? !(force_off_in || (!want_lo && lo_may_turn))
                 : (want_lo && !force_off_in && !hi_reg && lo_may_turn
                    && t_hi_reg >= DEAD_CYC);

  // saturating timers since each command last changed
  assign t_hi_next = (hi_next != hi_reg) ? TMR_ZERO
                   : (hi_may_turn ? t_hi_reg : t_hi_reg + 5'h01);
  assign t_lo_next = (lo_next != lo_reg) ? TMR_ZERO
                   : (lo_may_turn ? t_lo_reg : t_lo_reg + 5'h01);

  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hi_reg   <= LEG_CMD_RST;
      lo_reg   <= LEG_CMD_RST;
      t_hi_reg <= TMR_ZERO;
      t_lo_reg <= TMR_ZERO;
    end else begin
      hi_reg   <= hi_next;
      lo_reg   <= lo_next;
      t_hi_reg <= t_hi_next;
      t_lo_reg <= t_lo_next;
    end
  end

  assign leg_out.high = hi_reg;
  assign leg_out.low  = lo_reg;

  // checks on the leg
  no_shoot_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(hi_reg && lo_reg)) else $error("both gate commands high");
  hi_dead_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(hi_reg) |-> ($past(t_lo_reg) >= DEAD_CYC && !$past(lo_reg)))
    else $error("high command raised inside dead time");
  lo_dead_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(lo_reg) |-> ($past(t_hi_reg) >= DEAD_CYC && !$past(hi_reg)))
    else $error("low command raised inside dead time");
  hi_width_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ($fell(hi_reg) && !$past(force_off_in)) || $rose(hi_reg) |-> $past(t_hi_reg) >= PULSE_CYC)
    else $error("high command pulse too short");
  lo_width_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ($fell(lo_reg) && !$past(force_off_in)) || $rose(lo_reg) |-> $past(t_lo_reg) >= PULSE_CYC)
    else $error("low command pulse too short");
  force_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    force_off_in |=> !hi_reg && !lo_reg) else $error("leg not off after force");

endmodule
`default_nettype wire

// File: test/tb_three_phase_gate_interlock.sv
// self-checking bench for the gate command controller against the module model
`timescale 1ns/10ps
`default_nettype none
module tb_three_phase_gate_interlock;
  import tgi_pkg::*;
  typedef struct packed {
    logic [1:0] a, b, c;
    logic [2:0] hi, lo;
  } tgi_row_t;
  logic clk_in = 1'b0, rst_in = 1'b1, enable_req = 1'b0, fault_clear = 1'b0;
  logic [1:0] req_a = 2'h0, req_b = 2'h0, req_c = 2'h0;
  logic trip = 1'b0, main_uv = 1'b0;
  logic [2:0] float_uv = 3'h0, hi, lo;
  logic fault_w, run_w, line_o_w, oe_n_w, sink_w;
  wire logic line_w;
  tgi_leg_t [2:0] phase;
  tgi_row_t rows [6];
  int error_cnt = 0, checks_done = 0, n;
  // open-drain line with pull-up, either side may sink it
  assign line_w = ~((~oe_n_w & ~line_o_w) | sink_w);
  always #20 clk_in = ~clk_in;
  tgi_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .req_phase_a_in(req_a),
    .req_phase_b_in(req_b), .req_phase_c_in(req_c), .enable_req_in(enable_req),
    .fault_clear_in(fault_clear), .fault_out(fault_w), .running_out(run_w),
    .high_cmd_phase_a_out(hi[0]), .high_cmd_phase_b_out(hi[1]), .high_cmd_phase_c_out(hi[2]),
    .low_cmd_phase_a_out(lo[0]), .low_cmd_phase_b_out(lo[1]), .low_cmd_phase_c_out(lo[2]),
    .enable_fault_line_in(line_w), .enable_fault_line_out(line_o_w),
    .enable_fault_line_oe_n_out(oe_n_w));
  tgi_dev_model #(.CLR_CYC(8)) model (.clk_in(clk_in), .rst_in(rst_in), .high_cmd_in(hi),
    .low_cmd_in(lo), .line_in(line_w), .trip_in(trip), .main_uv_in(main_uv),
    .float_uv_in(float_uv), .sink_out(sink_w), .phase_out(phase));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // count edges until one command pin reaches a level
  task automatic span(input int p, input bit hs, input logic v, output int k);
    k = 0;
    while (((hs ? hi[p] : lo[p]) !== v) && k < 200) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end
  initial begin
    rows = '{'{2'h1, 2'h2, 2'h0, 3'h1, 3'h2}, '{2'h2, 2'h1, 2'h1, 3'h6, 3'h1},
             '{2'h0, 2'h0, 2'h2, 3'h0, 3'h4}, '{2'h3, 2'h3, 2'h3, 3'h0, 3'h0},
             '{2'h1, 2'h1, 2'h1, 3'h7, 3'h0}, '{2'h2, 2'h2, 2'h2, 3'h0, 3'h7}};
    cyc(3);
    rst_in <= 1'b0;
    cyc(1);
    chk({hi, lo, oe_n_w, run_w, fault_w, line_o_w} === 10'h000, "reset state");
    enable_req <= 1'b1;
    cyc(40);
    chk(run_w === 1'b1 && oe_n_w === 1'b1 && line_w === 1'b1, "not running");
    // table of request codes against command pins and phase states
    foreach (rows[r]) begin
      @(posedge clk_in);
      {req_a, req_b, req_c} <= {rows[r].a, rows[r].b, rows[r].c};
      cyc(80);
      chk({hi, lo} === {rows[r].hi, rows[r].lo}, "command pins");
      for (int i = 0; i < 3; i++) chk(phase[i] === {rows[r].hi[i], rows[r].lo[i]}, "phase");
    end
    // ground to bus keeps dead time, then a short request keeps minimum on-time
    @(posedge clk_in);
    req_a <= 2'h1;
    span(0, 1'b0, 1'b0, n);
    span(0, 1'b1, 1'b1, n);
    chk(n >= 13, "dead time short");
    @(posedge clk_in);
    req_a <= 2'h0;
    span(0, 1'b1, 1'b0, n);
    chk(n >= 24, "on pulse short");
    // float undervoltage drops only that high side and latches it
    @(posedge clk_in);
    req_a <= 2'h1;
    cyc(80);
    float_uv <= 3'h1;
    cyc(3);
    chk(phase === 6'h14, "float uv phase");
    float_uv <= 3'h0;
    cyc(3);
    chk(phase === 6'h14, "latch released early");
    req_a <= 2'h0;
    cyc(40);
    req_a <= 2'h1;
    cyc(80);
    chk(phase === 6'h16, "latch not released");
    main_uv <= 1'b1;
    cyc(2);
    chk(phase === 6'h00, "main uv");
    main_uv <= 1'b0;
    cyc(1);
    chk(phase === 6'h16, "main uv resume");
    // overcurrent trip sinks the line, controller drops all commands
    trip <= 1'b1;
    cyc(6);
    chk(fault_w === 1'b1 && {hi, lo} === 6'h00 && phase === 6'h00, "trip");
    trip <= 1'b0;
    cyc(2);
    chk(line_w === 1'b0, "line released early");
    cyc(12);
    chk(line_w === 1'b1, "line held");
    fault_clear <= 1'b1;
    @(posedge clk_in);
    fault_clear <= 1'b0;
    cyc(3);
    chk(run_w === 1'b1 && fault_w === 1'b0, "fault clear");
    cyc(80);
    chk(phase === 6'h16, "trip resume");
    enable_req <= 1'b0;
    cyc(3);
    chk(oe_n_w === 1'b0 && line_w === 1'b0 && {hi, lo, run_w} === 7'h00, "disable");
    // reset in mid-run with enable already asked for
    rst_in <= 1'b1;
    enable_req <= 1'b1;
    cyc(2);
    chk({hi, lo, oe_n_w, run_w, fault_w, line_o_w} === 10'h000, "mid-run reset");
    rst_in <= 1'b0;
    cyc(40);
    chk(run_w === 1'b1 && line_w === 1'b1 && phase === 6'h16, "restart after reset");
    // a clear while the line is still low is refused, the flag stays until cleared
    trip <= 1'b1;
    cyc(6);
    fault_clear <= 1'b1;
    cyc(1);
    fault_clear <= 1'b0;
    cyc(1);
    chk(fault_w === 1'b1 && run_w === 1'b0 && {hi, lo} === 6'h00, "clear refused");
    trip <= 1'b0;
    cyc(20);
    chk(line_w === 1'b1 && fault_w === 1'b1, "fault not sticky");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: test/tgi_dev_model.sv
// behavioural model of the three-phase power module seen from its logic pins
`timescale 1ns/10ps
`default_nettype none
module tgi_dev_model
  import tgi_pkg::*;
#(
  parameter int CLR_CYC = 8
)(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // gate commands and shared line level
  input  wire logic [2:0] high_cmd_in,
  input  wire logic [2:0] low_cmd_in,
  input  wire logic       line_in,
  // supply and overcurrent conditions
  input  wire logic       trip_in,
  input  wire logic       main_uv_in,
  input  wire logic [2:0] float_uv_in,
  // line sink and phase state, high = tied to bus, low = tied to ground
  output logic            sink_out,
  output tgi_leg_t [2:0]  phase_out
);
  logic [7:0] hold_reg;
  logic [2:0] lock_reg;
  wire logic  block_w;
  // fault hold counter, reloaded while tripped
  always_ff @(posedge clk_in) begin
    if (rst_in) hold_reg <= 8'h00;
    else if (trip_in) hold_reg <= 8'(CLR_CYC);
    else if (hold_reg != 8'h00) hold_reg <= hold_reg - 8'h01;
  end
  // high side stays locked after float undervoltage until its command drops
  always_ff @(posedge clk_in) begin
    if (rst_in) lock_reg <= 3'h0;
    else lock_reg <= (lock_reg & high_cmd_in) | float_uv_in;
  end
  // line sink and shared shut-off, protections ahead of commands
  assign sink_out = trip_in | (hold_reg != 8'h00);
  assign block_w  = ~line_in | trip_in | main_uv_in | (hold_reg != 8'h00);
  // each phase on its own input pair, interlock applied last
  for (genvar i = 0; i < PHASES; i++) begin : g_ph
    assign phase_out[i].high = high_cmd_in[i] & ~low_cmd_in[i] & ~block_w
                               & ~lock_reg[i] & ~float_uv_in[i];
    assign phase_out[i].low  = low_cmd_in[i] & ~high_cmd_in[i] & ~block_w;
  end
endmodule
`default_nettype wire
